// File: hw/scan_params.svh
`ifndef SCAN_PARAMS_SVH
`define SCAN_PARAMS_SVH

// ----------------------------------------
// Sizes and reset values
// ----------------------------------------
`define STAGE_COUNT        32
`define STAGE_RESET        32'hFFFF_FFFF
`define OE_OFF             32'h0000_0000
`define SYNC_RESET         3'h0
`define BUF_DEPTH          2

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS      100
`define SHIFT_PERIOD_NS    5000
`define SHIFT_PERIOD_CYC   ((`SHIFT_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------
// Bit positions in the synchroniser vector
// ----------------------------------------
`define PIN_SCLK           0
`define PIN_DATA           1
`define PIN_GATE           2

`endif

// File: hw/scan_pkg.sv
`include "scan_params.svh"

package scan_pkg;
	typedef logic [`STAGE_COUNT-1:0] stage_vec_t;
	typedef logic [2:0]              pin_vec_t;
endpackage

// File: hw/pair_buffer.sv
`timescale 1ns/1ps
`include "scan_params.svh"

module pair_buffer #(
	parameter int WIDTH = 1,
	parameter int DEPTH = `BUF_DEPTH
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_reg;
	logic [AW-1:0]    rd_reg;
	logic [AW:0]      count_reg;
	logic             push;
	logic             pop;

	assign in_ready  = (count_reg != (AW+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign out_data  = mem_reg[rd_reg];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge clk)
	begin
		if (push)
			mem_reg[wr_reg] <= in_data;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wr_reg <= '0;
			rd_reg <= '0;
		end
		else
		begin
			if (push)
				wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : AW'(wr_reg + 1'b1);
			if (pop)
				rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : AW'(rd_reg + 1'b1);
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			count_reg <= '0;
		else if (push && !pop)
			count_reg <= count_reg + 1'b1;
		else if (pop && !push)
			count_reg <= count_reg - 1'b1;
	end

	count_bound_a: assert property (@(posedge clk) disable iff (rst)
		count_reg <= (AW+1)'(DEPTH))
		else $error("buffer count above depth");
endmodule // pair_buffer

// File: hw/scan_line_shift_driver.sv
// Function
// - Each falling shift-clock edge shifts the 32 stages once; otherwise they hold.
// - Each stage takes the one below; first stage takes serial data.
// - Gate low turns every scan line off, whatever the stages hold.
// - Cascade output always shows the last stage, ignoring the gate.
// - Gate high: a line sinks current when its stage holds low.
// - Cascade output feeds the next device's data input for chaining.
`timescale 1ns/1ps
`include "scan_params.svh"

module scan_line_shift_driver #(
	parameter int STAGES = `STAGE_COUNT
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              shift_clk,
	input  wire logic              serial_in,
	input  wire logic              out_gate,
	output logic                   cascade_out,
	output logic [STAGES-1:0]      scan_line_out,
	output logic [STAGES-1:0]      scan_line_oe,
	output logic                   shift_ready,
	output logic                   cascade_valid,
	input  wire logic              cascade_ready,
	output logic                   cascade_data
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	scan_pkg::pin_vec_t  sync1_reg;
	scan_pkg::pin_vec_t  sync2_reg;
	scan_pkg::pin_vec_t  sync3_reg;
	scan_pkg::pin_vec_t  level_reg;
	scan_pkg::pin_vec_t  agree;
	logic                shift_fall;
	logic [STAGES-1:0]   stages_reg;
	logic [STAGES-1:0]   oe_reg;

	// The first flop may go metastable; only the second and third vote
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sync1_reg <= `SYNC_RESET;
			sync2_reg <= `SYNC_RESET;
			sync3_reg <= `SYNC_RESET;
		end
		else
		begin
			sync1_reg <= {out_gate, serial_in, shift_clk};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	// A level counts only once the second and third flops agree
	assign agree = ~(sync2_reg ^ sync3_reg);

	// A pin that is still settling keeps its last accepted level
	always_ff @(posedge clk)
	begin
		if (rst)
			level_reg <= `SYNC_RESET;
		else
			level_reg <= (agree & sync3_reg) | (~agree & level_reg);
	end

	// Edge taken from accepted levels only, so a slow ramp shifts once
	assign shift_fall = level_reg[`PIN_SCLK] && agree[`PIN_SCLK]
		&& !sync3_reg[`PIN_SCLK];

	// ----------------------------------------
	// Shift stages
	// ----------------------------------------
	// Data rides the same three-flop delay as the clock, so it is sampled
	// where the controller's set-up and hold straddle the falling edge.
	always_ff @(posedge clk)
	begin
		if (rst)
			stages_reg <= STAGES'(`STAGE_RESET);
		else if (shift_fall)
			stages_reg <= {stages_reg[STAGES-2:0], sync3_reg[`PIN_DATA]};
	end

	assign cascade_out = stages_reg[STAGES-1];

	// ----------------------------------------
	// Scan-line open-drain outputs
	// ----------------------------------------
	// One clock of lag behind the stages and gate; far below the pin delays.
	always_ff @(posedge clk)
	begin
		if (rst)
			oe_reg <= STAGES'(`OE_OFF);
		else if (!level_reg[`PIN_GATE])
			oe_reg <= STAGES'(`OE_OFF);
		else
			oe_reg <= ~stages_reg;
	end

	assign scan_line_oe  = oe_reg;
	// The lines only sink current, so the data side of each pin stays low
	assign scan_line_out = '0;

	// ----------------------------------------
	// Cascade bit stream
	// ----------------------------------------
	// The shift clock cannot be held off, so a full buffer drops the bit;
	// shift_ready tells the controller to pause its shifting.
	pair_buffer #(
		.WIDTH (1),
		.DEPTH (`BUF_DEPTH)
	) cascade_buf (
		.clk       (clk),
		.rst       (rst),
		.in_valid  (shift_fall),
		.in_ready  (shift_ready),
		.in_data   (stages_reg[STAGES-2]),
		.out_valid (cascade_valid),
		.out_ready (cascade_ready),
		.out_data  (cascade_data)
	);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Cycles since the last detected fall; saturates so a long pause never wraps
	logic [15:0] gap_cnt_reg;

	always_ff @(posedge clk)
	begin
		if (rst || shift_fall)
			gap_cnt_reg <= '0;
		else if (gap_cnt_reg != 16'hFFFF)
			gap_cnt_reg <= gap_cnt_reg + 16'h0001;
	end

	// ----------------------------------------
	// Shift path
	// ----------------------------------------
	stage_hold_a: assert property (!shift_fall |=> $stable(stages_reg))
		else $error("stages changed without a falling shift edge");

	// A long low phase must still count as one edge, not one per clock
	fall_once_a: assert property (shift_fall |=> !shift_fall)
		else $error("one falling edge shifted twice");

	shift_move_a: assert property (shift_fall |=>
		stages_reg[STAGES-1:1] == $past(stages_reg[STAGES-2:0]))
		else $error("stages did not move up by one place");

	first_stage_a: assert property (shift_fall |=>
		stages_reg[0] == $past(sync3_reg[`PIN_DATA]))
		else $error("first stage missed serial data");

	// ----------------------------------------
	// Scan lines
	// ----------------------------------------
	// Off means the line driver is released, never driven
	gate_off_a: assert property (!level_reg[`PIN_GATE] |=> scan_line_oe == '0)
		else $error("line driven while gate low");

	line_follow_a: assert property (level_reg[`PIN_GATE] |=>
		scan_line_oe == ~$past(stages_reg))
		else $error("line does not follow its stage");

	// No glitch on a line while nothing that selects it moves
	line_still_a: assert property ($stable(stages_reg)
		&& $stable(level_reg[`PIN_GATE]) |=> $stable(scan_line_oe))
		else $error("line changed with stages and gate steady");

	// ----------------------------------------
	// Cascade output and stream
	// ----------------------------------------
	cascade_tap_a: assert property (!shift_fall |=> $stable(cascade_out))
		else $error("cascade changed without a shift");

	// The next device sees the bit that stage thirty-one held before the shift
	chain_feed_a: assert property (shift_fall |=>
		cascade_out == $past(stages_reg[STAGES-2]))
		else $error("cascade bit out of order");

	// A bit accepted by the buffer must be offered downstream
	push_taken_a: assert property (shift_fall && shift_ready |=> cascade_valid)
		else $error("accepted bit not offered downstream");

	// With the buffer empty the pushed bit is the head word at once
	first_word_a: assert property (shift_fall && shift_ready && !cascade_valid
		|=> cascade_data == cascade_out)
		else $error("head word differs from the last stage");

	// A receiver stall must never lose or alter the head word
	held_word_a: assert property (cascade_valid && !cascade_ready
		|=> cascade_valid && $stable(cascade_data))
		else $error("stalled word changed or vanished");

	// A bit dropped on a full buffer leaves the stored words untouched
	stall_drop_a: assert property (shift_fall && !shift_ready && !cascade_ready
		|=> !shift_ready && $stable(cascade_data))
		else $error("dropped bit disturbed the buffer");

	pop_free_a: assert property (cascade_valid && cascade_ready && !shift_fall
		|=> shift_ready)
		else $error("no room after a word was taken");

	drop_flag_a: assert property (!shift_ready |-> cascade_valid)
		else $error("buffer full yet nothing to drain");

	// ----------------------------------------
	// Coverage
	// ----------------------------------------
	shift_seen_c:  cover property (shift_fall ##[1:100] shift_fall);
	line_on_c:     cover property (level_reg[`PIN_GATE] ##1 (scan_line_oe != '0));
	buf_full_c:    cover property (!shift_ready);
	slow_shift_c:  cover property (shift_fall && gap_cnt_reg >= 16'(`SHIFT_PERIOD_CYC));
	chain_low_c:   cover property (shift_fall ##1 !cascade_out);
endmodule // scan_line_shift_driver

// File: tb/scan_ctrl_model.sv
`timescale 1ns/1ps

module scan_ctrl_model (
	input  wire logic clk,
	output logic      shift_clk,
	output logic      serial_in,
	output logic      out_gate
);
	initial
	begin
		shift_clk = 1'b0;
		serial_in = 1'b1;
		out_gate  = 1'b0;
	end

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// One bit per call; the gate stays low while shifting
	// A period of 50 cycles keeps the shift clock at 5 us
	task automatic shift_bit(input logic b);
		serial_in = b;
		shift_clk = 1'b1;
		step(25);
		shift_clk = 1'b0;
		// Past the hold time the data line no longer shows the bit
		step(13);
		serial_in = ~b;
		step(12);
	endtask

	// Callers shift a single low bit per 32
	// On-time clamped to 100 us, off-time 199 times the on-time
	task automatic show(input int n);
		int t;
		t = (n > 1000) ? 1000 : n;
		out_gate = 1'b1;
		step(t);
		out_gate = 1'b0;
		step(199 * t);
	endtask
endmodule // scan_ctrl_model

// File: tb/scan_line_shift_driver_tb.sv
`timescale 1ns/1ps
`include "scan_params.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[FAIL] %s expected %h seen %h", nm, e, g); end end

module scan_line_shift_driver_tb;
	logic                    clk;
	logic                    rst;
	logic                    cascade_ready;
	wire logic               shift_clk, serial_in, out_gate;
	wire logic               cascade_out, shift_ready, cascade_valid, cascade_data;
	wire logic [`STAGE_COUNT-1:0] scan_line_out, scan_line_oe;
	int                      n_mismatch = 0;
	int                      num_checks = 0;

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	scan_ctrl_model i_ctrl (.clk(clk), .shift_clk(shift_clk), .serial_in(serial_in),
		.out_gate(out_gate));

	scan_line_shift_driver i_dut (.clk(clk), .rst(rst), .shift_clk(shift_clk),
		.serial_in(serial_in), .out_gate(out_gate), .cascade_out(cascade_out),
		.scan_line_out(scan_line_out), .scan_line_oe(scan_line_oe),
		.shift_ready(shift_ready), .cascade_valid(cascade_valid),
		.cascade_ready(cascade_ready), .cascade_data(cascade_data));

	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic check_reset();
		`CHK("cascade_out", 1'b1, cascade_out)
		`CHK("scan_line_oe", 32'h0000_0000, scan_line_oe)
		`CHK("cascade_valid", 1'b0, cascade_valid)
		`CHK("shift_ready", 1'b1, shift_ready)
	endtask

	// Low bit then 30 ones leaves it in stage 31 of 32
	task automatic check_display();
		i_ctrl.shift_bit(1'b0);
		repeat (30) i_ctrl.shift_bit(1'b1);
		`CHK("oe gate low", 32'h0000_0000, scan_line_oe)
		`CHK("line data", 32'h0000_0000, scan_line_out)
		fork
			i_ctrl.show(20);
			begin
				i_ctrl.step(10);
				`CHK("oe gate high", 32'h4000_0000, scan_line_oe)
				`CHK("cascade gate high", 1'b1, cascade_out)
			end
		join
		`CHK("oe gate off", 32'h0000_0000, scan_line_oe)
		`CHK("no push on gate", 1'b0, cascade_valid)
	endtask

	// Receiver stalls: two words kept, third dropped, then drained in order
	task automatic check_buffer();
		cascade_ready = 1'b0;
		i_ctrl.shift_bit(1'b1);
		`CHK("cascade low bit", 1'b0, cascade_out)
		`CHK("first valid", 1'b1, cascade_valid)
		`CHK("room left", 1'b1, shift_ready)
		repeat (2) i_ctrl.shift_bit(1'b1);
		`CHK("full ready", 1'b0, shift_ready)
		`CHK("full valid", 1'b1, cascade_valid)
		`CHK("head word", 1'b0, cascade_data)
		`CHK("cascade after 3", 1'b1, cascade_out)
		cascade_ready = 1'b1;
		i_ctrl.step(1);
		`CHK("second word", 1'b1, cascade_data)
		`CHK("second valid", 1'b1, cascade_valid)
		i_ctrl.step(1);
		`CHK("drained", 1'b0, cascade_valid)
		`CHK("ready again", 1'b1, shift_ready)
	endtask

	initial
	begin
		rst           = 1'b1;
		cascade_ready = 1'b1;
		repeat (20) @(posedge clk);
		#1;
		rst = 1'b0;
		i_ctrl.step(2);
		check_reset();
		check_display();
		check_buffer();
		wrap_up();
	end

	// Tests need about 5,700 cycles
	initial
	begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		wrap_up();
	end
endmodule // scan_line_shift_driver_tb
